// ===== sar_map.svh
// Named constants for the SAR converter readout block.
// Assumes inclusion by bare name from every file that needs these figures.
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH

// ==========================================================================
// Conversion format
`define SAR_BITS          18
`define SAR_SIGN_MASK     18'h20000
`define SAR_MSB_ONLY      18'h20000
`define SAR_ZERO_CODE     18'h00000

// ==========================================================================
// Serial framing
`define SAR_LEAD_BITS     3
`define SAR_IDX_W         5
`define SAR_IDX_ZERO      5'h00
`define SAR_IDX_ONE       5'h01
`define SAR_IDX_TWO       5'h02

// ==========================================================================
// Buffering
`define SAR_FIFO_DEPTH    32

// ==========================================================================
// Timing
`define SAR_CLK_MHZ       10
`define SAR_MSB_READY_NS  2000
`define SAR_MSB_READY_CYC ((`SAR_MSB_READY_NS * `SAR_CLK_MHZ + 999) / 1000)
`define SAR_TMR_W         8
`define SAR_TMR_ZERO      8'h00

`endif

// ===== sar_pkg.sv
// Types shared by the SAR converter readout block.
// Assumes no surroundings beyond the compile order.
package sar_pkg;

  // ========================================================================
  // Conversion sequencer states
  typedef enum logic [1:0] {
    SAR_ST_ACQ  = 2'b00,
    SAR_ST_CONV = 2'b01,
    SAR_ST_WAIT = 2'b10
  } sar_state_t;

endpackage

// ===== sar_readout.sv
// Conversion control, result buffer and serial readout of an 18-bit SAR ADC.
// Assumes an on-chip comparator on the system clock and a host-driven burst shift clock.
`timescale 1ns/1ps
`default_nettype none
`include "sar_map.svh"

// ==========================================================================
// Result FIFO
module sar_fifo #(
  parameter int WIDTH = `SAR_BITS,
  parameter int DEPTH = `SAR_FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             en_i,
  input  wire logic             in_valid_i,
  output var  logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output var  logic             out_valid_o,
  input  wire logic             out_ready_i,
  output var  logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Handshakes on both sides
  // Full at exactly DEPTH words, so every entry is used
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  // Storage, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (en_i && push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (en_i) begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      end
      if (push && !pop) begin
        count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
        count <= count - (AW+1)'(1);
      end
    end
  end
endmodule

// Behaviour
// - Conversion phase begins on the rising edge of conversion start after acquisition.
// - Conversion start is taken as a CMOS level or a differential pair.
// - Data read after a start edge belongs to that same conversion, no pipeline; the code reads out the oldest unread buffered result instead.
// - Result readable only after the MSB-ready time; host bursts the shift clock.
// - Eighteen-bit result goes out serially, MSB first, twos complement.
// - Full scale less one 1ffff, mid plus one 00001, mid 00000, mid less one 3ffff.
// - Negative full scale gives 20000, negative full scale plus one gives 20001.
// - Bits are decided MSB first over eighteen binary weighted steps, then coded.
// - Each output bit changes on the falling edge of the shift clock.
// - Echoed clock leg tied low selects self-clocked mode, otherwise echoed-clock mode.
// - Self-clocked frame sends 0, header 10, then the eighteen result bits.
// - Echoed-clock mode echoes the shift clock; host captures on the next rising edge.
module sar_readout #(
  parameter int DATA_W     = `SAR_BITS,
  parameter int FIFO_DEPTH = `SAR_FIFO_DEPTH
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              en_i,
  input  wire logic              cnv_lvds_sel_i,
  input  wire logic              conversion_start_cmos_i,
  input  wire logic              conversion_start_p_i,
  input  wire logic              conversion_start_n_i,
  input  wire logic              cmp_i,
  input  wire logic              clk_link_i,
  input  wire logic              echo_sense_i,
  output var  logic              sampling_o,
  output var  logic              busy_o,
  output var  logic [DATA_W-1:0] dac_code_o,
  output var  logic              data_o,
  output var  logic              echoed_clock_out_o
);
  // Counter limits, each cut to the width of the counter it meets
  localparam logic [`SAR_TMR_W-1:0] MSB_CYC     = `SAR_TMR_W'(`SAR_MSB_READY_CYC);
  localparam logic [`SAR_IDX_W-1:0] LAST_SELF   = `SAR_IDX_W'(DATA_W + `SAR_LEAD_BITS - 1);
  localparam logic [`SAR_IDX_W-1:0] LAST_ECHO   = `SAR_IDX_W'(DATA_W - 1);
  localparam logic [`SAR_IDX_W-1:0] LEAD_BITS   = `SAR_IDX_W'(`SAR_LEAD_BITS);
  localparam logic [`SAR_IDX_W-1:0] MSB_IDX     = `SAR_IDX_W'(DATA_W - 1);

  // ========================================================================
  // System-domain input synchronisers
  logic cmos_s1, cmos_s2, cnvp_s1, cnvp_s2, cnvn_s1, cnvn_s2;
  logic sel_s1, sel_s2;
  logic cnv_level, cnv_prev, cnv_rise;

  // Every start and select pin passes two flops before any logic looks at it
  // Two cycles of start latency are the price of a safe pin
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      {cmos_s1, cmos_s2, cnvp_s1, cnvp_s2} <= 4'h0;
      {cnvn_s1, cnvn_s2, sel_s1, sel_s2}   <= 4'h0;
    end else if (en_i) begin
      cmos_s1 <= conversion_start_cmos_i;
      cmos_s2 <= cmos_s1;
      cnvp_s1 <= conversion_start_p_i;
      cnvp_s2 <= cnvp_s1;
      cnvn_s1 <= conversion_start_n_i;
      cnvn_s2 <= cnvn_s1;
      sel_s1  <= cnv_lvds_sel_i;
      sel_s2  <= sel_s1;
    end
  end

  // Differential start reads high when the positive leg leads
  assign cnv_level = sel_s2 ? (cnvp_s2 & ~cnvn_s2) : cmos_s2;
  assign cnv_rise  = cnv_level & ~cnv_prev;

  // Last level seen; resets low like the idle pin, so no false edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnv_prev <= 1'b0;
    end else if (en_i) begin
      cnv_prev <= cnv_level;
    end
  end

  // ========================================================================
  // Successive approximation sequencer
  sar_pkg::sar_state_t state;
  logic [`SAR_IDX_W-1:0] bit_idx;
  logic [`SAR_TMR_W-1:0] timer;
  logic [DATA_W-1:0]     next_dac;
  logic                  fifo_in_ready;
  logic                  push;

  // Keep or drop the trial bit, then try the next lower weight
  always_comb begin
    next_dac = dac_code_o;
    if (!cmp_i) begin
      next_dac[bit_idx] = 1'b0;
    end
    if (bit_idx != `SAR_IDX_ZERO) begin
      next_dac[bit_idx - `SAR_IDX_ONE] = 1'b1;
    end
  end

  // Push waits for the trials and for the MSB-ready time
  // A full buffer stalls the sequencer, so starts are ignored until it drains
  assign push = (state == sar_pkg::SAR_ST_WAIT) && (timer >= MSB_CYC) && fifo_in_ready;

  // Acquire, run eighteen trials, then wait for the MSB-ready time
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state      <= sar_pkg::SAR_ST_ACQ;
      bit_idx    <= `SAR_IDX_ZERO;
      dac_code_o <= `SAR_ZERO_CODE;
      sampling_o <= 1'b1;
      busy_o     <= 1'b0;
    end else if (en_i) begin
      case (state)
        sar_pkg::SAR_ST_ACQ: begin
          if (cnv_rise) begin
            state      <= sar_pkg::SAR_ST_CONV;
            bit_idx    <= MSB_IDX;
            dac_code_o <= `SAR_MSB_ONLY;
            sampling_o <= 1'b0;
            busy_o     <= 1'b1;
          end
        end
        sar_pkg::SAR_ST_CONV: begin
          dac_code_o <= next_dac;
          if (bit_idx == `SAR_IDX_ZERO) begin
            state <= sar_pkg::SAR_ST_WAIT;
          end else begin
            bit_idx <= bit_idx - `SAR_IDX_ONE;
          end
        end
        sar_pkg::SAR_ST_WAIT: begin
          if (push) begin
            state      <= sar_pkg::SAR_ST_ACQ;
            sampling_o <= 1'b1;
            busy_o     <= 1'b0;
          end
        end
        default: begin
          state <= sar_pkg::SAR_ST_ACQ;
        end
      endcase
    end
  end

  // Time since the start edge, saturating at the MSB-ready count
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      timer <= `SAR_TMR_ZERO;
    end else if (en_i) begin
      if (state == sar_pkg::SAR_ST_ACQ) begin
        timer <= cnv_rise ? `SAR_TMR_W'(1) : `SAR_TMR_ZERO;
      end else if (timer < MSB_CYC) begin
        timer <= timer + `SAR_TMR_W'(1);
      end
    end
  end

  // ========================================================================
  // Result buffer and word handed to the link
  logic              fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic [DATA_W-1:0] hold_word;
  logic              hold_valid;
  logic              ack_s1, ack_s2, ack_s3;
  logic              ack_toggle;

  // Offset-binary search result becomes twos complement by flipping the sign
  sar_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_sys_i),
    .rst_i       (rst_i),
    .en_i        (en_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (dac_code_o ^ DATA_W'(`SAR_SIGN_MASK)),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (~hold_valid),
    .out_data_o  (fifo_out_data)
  );

  // Acknowledge toggle from the link domain
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      {ack_s1, ack_s2, ack_s3} <= 3'h0;
    end else if (en_i) begin
      ack_s1 <= ack_toggle;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end

  // Word stays still while the link reads it; only a finished burst frees it
  // A burst begun before a word is held shifts the stale one; the host must wait
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hold_word  <= `SAR_ZERO_CODE;
      hold_valid <= 1'b0;
    end else if (en_i) begin
      if (ack_s2 ^ ack_s3) begin
        hold_valid <= 1'b0;
      end else if (!hold_valid && fifo_out_valid) begin
        hold_word  <= fifo_out_data;
        hold_valid <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Link domain, clocked by falling edges of the host shift clock
  logic                  rst_l1, rst_l2;
  logic                  sense_s1, sense_s2;
  logic                  self_mode;
  logic [`SAR_IDX_W-1:0] pos;
  logic                  next_bit;
  logic [`SAR_IDX_W-1:0] word_pos;
  logic                  last_pos;
  logic                  frame_self;

  // Reset and mode strap reach this domain through two flops
  always_ff @(negedge clk_link_i) begin
    rst_l1   <= rst_i;
    rst_l2   <= rst_l1;
    sense_s1 <= echo_sense_i;
    sense_s2 <= sense_s1;
  end

  // Strap is taken at frame start, and the first bit of that frame obeys it already
  assign frame_self = (pos == `SAR_IDX_ZERO) ? ~sense_s2 : self_mode;

  // Frame position picks header or result bit, MSB first
  always_comb begin
    word_pos = frame_self ? (pos - LEAD_BITS) : pos;
    if (frame_self && pos == `SAR_IDX_ZERO) begin
      next_bit = 1'b0;
    end else if (frame_self && pos == `SAR_IDX_ONE) begin
      next_bit = 1'b1;
    end else if (frame_self && pos == `SAR_IDX_TWO) begin
      next_bit = 1'b0;
    end else begin
      next_bit = hold_word[MSB_IDX - word_pos];
    end
  end

  // Last position of the frame in the mode that frame runs in
  assign last_pos = frame_self ? (pos == LAST_SELF) : (pos == LAST_ECHO);

  // Mode is sampled only between frames so a burst never changes length midway
  always_ff @(negedge clk_link_i) begin
    if (rst_l2) begin
      pos        <= `SAR_IDX_ZERO;
      self_mode  <= 1'b0;
      data_o     <= 1'b0;
      ack_toggle <= 1'b0;
    end else begin
      if (pos == `SAR_IDX_ZERO) begin
        self_mode <= ~sense_s2;
      end
      data_o <= next_bit;
      if (last_pos) begin
        pos        <= `SAR_IDX_ZERO;
        ack_toggle <= ~ack_toggle;
      end else begin
        pos <= pos + `SAR_IDX_ONE;
      end
    end
  end

  // Echo must follow the shift clock itself, so it is gated rather than registered
  // In self-clocked mode the echo pin stays low
  assign echoed_clock_out_o = clk_link_i & sense_s2;
endmodule
`default_nettype wire

// ===== sar_host.sv
// Host model of the serial link: bursts the shift clock and captures bits.
// Assumes the bench calls burst in reset to clear the link, then only once a result is ready.
`timescale 1ns/1ps
`default_nettype none
// ====================
// Burst reader
module sar_host (
  output var  logic clk_link_o,
  input  wire logic data_i
);
  logic [31:0] word = 32'h00000000;
  // Clock idles high and still between bursts
  initial clk_link_o = 1'b1;
  // Device shifts on the fall, host captures on the next rise
  task automatic burst(input int n);
    word = 32'h00000000;
    repeat (n) begin
      #32 clk_link_o = 1'b0;
      #32 clk_link_o = 1'b1;
      word = {word[30:0], data_i};
    end
  endtask
endmodule
`default_nettype wire

// ===== sar_readout_properties.sv
// Concurrent checks on the ports of the readout block.
// Assumes binding onto every sar_readout instance.
`timescale 1ns/1ps
`default_nettype none
// ====================
// Conversion checker
module sar_props #(
  parameter int DATA_W = 18
) (
  input wire logic              clk_sys_i,
  input wire logic              rst_i,
  input wire logic              en_i,
  input wire logic              cmp_i,
  input wire logic              clk_link_i,
  input wire logic              sampling_o,
  input wire logic              busy_o,
  input wire logic [DATA_W-1:0] dac_code_o,
  input wire logic              echoed_clock_out_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Start seen with the clock enabled
  sequence s_go;
    $rose(busy_o) && en_i;
  endsequence
  // Trials run only while enabled, so slips show as wrong bits
  sequence s_trials;
    s_go ##1 en_i[*8] ##1 en_i[*8] ##1 en_i;
  endsequence
  chk_start_trial: assert property (s_go |-> !sampling_o && dac_code_o == 18'h20000)
    else $error("start did not load the first trial");
  chk_state_excl: assert property (busy_o |-> !sampling_o)
    else $error("busy while sampling");
  chk_msb_first: assert property (s_go |=> dac_code_o[17] == $past(cmp_i) && dac_code_o[16])
    else $error("top bit not decided first");
  chk_lsb_last: assert property (s_trials |=> dac_code_o[0] == $past(cmp_i))
    else $error("last bit not decided at step eighteen");
  chk_msb_wait: assert property (s_go |-> busy_o[*8] ##1 busy_o[*8] ##1 busy_o[*4])
    else $error("result released too early");
  chk_code_hold: assert property (sampling_o && $past(sampling_o) |-> $stable(dac_code_o))
    else $error("code moved during acquisition");
  chk_done_idle: assert property ($fell(busy_o) |-> sampling_o)
    else $error("no return to acquisition");
  chk_echo_copy: assert property (echoed_clock_out_o |-> clk_link_i)
    else $error("echoed clock high while shift clock low");
endmodule
bind sar_readout sar_props #(.DATA_W(DATA_W)) i_sar_props (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .en_i(en_i), .cmp_i(cmp_i), .clk_link_i(clk_link_i),
  .sampling_o(sampling_o), .busy_o(busy_o), .dac_code_o(dac_code_o),
  .echoed_clock_out_o(echoed_clock_out_o));
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the readout block with a host link model.
// Assumes design, checker and host model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sar_map.svh"
// ====================
// Bench top
module testbench;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        sel       = 1'b0;
  logic        st_c      = 1'b0;
  logic        st_p      = 1'b0;
  logic        st_n      = 1'b1;
  logic        echo      = 1'b1;
  logic        en        = 1'b1;
  logic [17:0] tgt       = 18'h00000;
  wire  logic  clk_link, data, sampling, busy, eco;
  wire  logic [17:0] dac;
  int          err_total, total_checks, cycles;
  // Ideal comparator: keep the trial bit while it does not overshoot
  wire  logic  cmp = (dac <= tgt);
  // Rows: lvds start, target word, expected code
  logic [36:0] rows [6] = '{{1'b0, 18'h3ffff, 18'h1ffff}, {1'b0, 18'h20001, 18'h00001},
    {1'b1, 18'h20000, 18'h00000}, {1'b0, 18'h1ffff, 18'h3ffff},
    {1'b1, 18'h00001, 18'h20001}, {1'b0, 18'h00000, 18'h20000}};
  always #50 clk_sys_i = ~clk_sys_i;
  sar_readout i_sar_readout (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .en_i(en),
    .cnv_lvds_sel_i(sel), .conversion_start_cmos_i(st_c), .conversion_start_p_i(st_p),
    .conversion_start_n_i(st_n), .cmp_i(cmp), .clk_link_i(clk_link), .echo_sense_i(echo),
    .sampling_o(sampling), .busy_o(busy), .dac_code_o(dac), .data_o(data), .echoed_clock_out_o(eco));
  sar_host i_sar_host (.clk_link_o(clk_link), .data_i(data));
  // ====================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait, so a stalled conversion cannot hang the run
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy !== lvl && k < 60) begin
      @(posedge clk_sys_i);
      k++;
    end
  endtask
  task automatic conv(input logic [17:0] t);
    @(posedge clk_sys_i);
    tgt  <= t;
    st_c <= 1'b1;
    st_p <= 1'b1;
    st_n <= 1'b0;
    wait_busy(1'b1);
    st_c <= 1'b0;
    st_p <= 1'b0;
    st_n <= 1'b1;
    wait_busy(1'b0);
  endtask
  // Gap lets the word cross into the link domain first
  task automatic rd(input int n, output logic [31:0] w);
    repeat (4) @(posedge clk_sys_i);
    #13;
    i_sar_host.burst(n);
    w = i_sar_host.word;
    repeat (10) @(posedge clk_sys_i);
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard, well above the few thousand cycles needed
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  // ====================
  // Main sequence
  initial begin
    logic [31:0] w;
    logic [17:0] d;
    fork
      i_sar_host.burst(4);
    join_none
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      sel <= rows[i][36];
      conv(rows[i][35:18]);
      chk({14'h0000, dac}, {14'h0000, rows[i][35:18]});
      rd(18, w);
      chk(w, {14'h0000, rows[i][17:0]});
      $display("row %0d done", i);
    end
    // Clock enable low in mid conversion freezes the trials
    tgt  <= 18'h0abcd;
    st_c <= 1'b1;
    wait_busy(1'b1);
    st_c <= 1'b0;
    en   <= 1'b0;
    @(posedge clk_sys_i);
    d = dac;
    repeat (4) @(posedge clk_sys_i);
    chk({14'h0000, dac}, {14'h0000, d});
    en <= 1'b1;
    wait_busy(1'b0);
    chk({14'h0000, dac}, 32'h0000abcd);
    rd(18, w);
    chk(w, {14'h0000, 18'h0abcd ^ `SAR_SIGN_MASK});
    $display("clock enable test done");
    // Reset in mid conversion
    sel  <= 1'b0;
    st_c <= 1'b1;
    wait_busy(1'b1);
    rst_i <= 1'b1;
    st_c  <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    chk({12'h000, sampling, busy, dac}, {12'h000, 1'b1, 1'b0, `SAR_ZERO_CODE});
    repeat (30) @(posedge clk_sys_i);
    $display("reset test done");
    // Fill link word and buffer, then one more conversion must stall
    for (int i = 0; i < 34; i++) conv(18'(i * 5));
    chk({31'h0, busy}, 32'h1);
    for (int i = 0; i < 34; i++) begin
      if (i == 33) echo <= 1'b0;
      rd(18, w);
      chk(w, {14'h0000, 18'(i * 5) ^ `SAR_SIGN_MASK});
      chk({31'h0, eco}, {31'h0, echo});
    end
    $display("buffer test done");
    // Self-clocked frame: lead 0, header 10, then the code
    conv(18'h3ffff);
    rd(21, w);
    chk(w, {11'h000, 3'b010, 18'h1ffff});
    conv(18'h00001);
    rd(21, w);
    chk(w, {11'h000, 3'b010, 18'h20001});
    $display("self-clocked test done");
    end_of_test();
  end
endmodule
`default_nettype wire
